// [sbr_dev.sv]
// support chip end: clocks, ready and wait states, decodes, dma hold
`timescale 1ns/1ps
module sbr_dev (
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	sbr_bus_if.dev           bus,
	input  wire logic        freq_tick_i,
	input  wire logic        dma_req_i,
	input  wire logic        dma_refresh_i,
	input  wire logic [19:0] dma_addr_i,
	input  wire logic [7:0]  own_io_rdata_i,
	output logic             timer_tick_o,
	output logic             dma_done_o
);
	typedef enum logic [5:0] {
		D_IDLE = 6'h01,
		D_T2   = 6'h02,
		D_T3   = 6'h04,
		D_TW   = 6'h08,
		D_T4   = 6'h10,
		D_DMA  = 6'h20
	} sbr_dst_e;

	typedef struct packed {
		sbr_dst_e                       st;
		sbr_pkg::sbr_kind_e             kind;
		logic [19:0]                    addr;
		logic                           refresh;
		logic [sbr_pkg::DMA_CNT_W-1:0]  cnt;
		logic [7:0]                     wdat;
		logic [7:0]                     rdat;
		logic                           done;
		logic                           rom_lo;
		logic                           rom_hi;
		logic                           crs;
		logic                           b0;
		logic                           b1;
		logic                           b2;
		logic                           prn;
		logic                           dir;
		logic                           den;
		logic                           ack0;
	} sbr_dev_s;

	localparam logic [sbr_pkg::DMA_CNT_W-1:0] DMA_LAST =
		sbr_pkg::DMA_CNT_W'(sbr_pkg::DMA_LEN - 1);

	sbr_dev_s q;
	sbr_dev_s next_q;
	logic     pce;
	logic     chan_ok;
	logic     io_q;
	logic     wr_q;
	logic     rd_q;
	logic     busy_q;
	logic     start_c;
	logic     held_c;
	logic     n_busy;
	logic     n_mem;
	logic     n_io;
	logic     n_dma;

	//////////////////////////////////////////////////////////////////////
	// clock dividers: the bus logic runs on the looped-back clock
	sbr_div #(
		.DIV       (sbr_pkg::PCLK_DIV)
	) u_pclk (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.en_i      (freq_tick_i),
		.pulse_o   (bus.processor_clock_out)
	);

	sbr_div #(
		.DIV       (sbr_pkg::TIMER_DIV)
	) u_tclk (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.en_i      (bus.processor_clock_in),
		.pulse_o   (timer_tick_o)
	);

	//////////////////////////////////////////////////////////////////////
	// cycle qualifiers
	assign pce     = bus.processor_clock_in;
	assign chan_ok = bus.channel_go_high & ~bus.channel_wait_high;
	assign io_q    = (q.kind == sbr_pkg::IO_RD) | (q.kind == sbr_pkg::IO_WR);
	assign wr_q    = (q.kind == sbr_pkg::IO_WR) | (q.kind == sbr_pkg::MEM_WR);
	assign rd_q    = (q.kind == sbr_pkg::IO_RD) | (q.kind == sbr_pkg::MEM_RD);
	assign busy_q  = q.st inside {D_T2, D_T3, D_TW, D_T4};
	assign start_c = bus.proc_status inside {sbr_pkg::IO_RD, sbr_pkg::IO_WR,
		sbr_pkg::MEM_RD, sbr_pkg::MEM_WR};

	// combinational so the processor sees the grant before its next
	// clock and cannot open a cycle in the same step
	assign held_c = (q.st == D_DMA) | ((q.st == D_IDLE) & dma_req_i
		& ~bus.bus_hold_lock & ~start_c);

	// ready: i/o always waits once, memory only when a line says so
	assign bus.ready = (q.st == D_T3) ? (~io_q & chan_ok)
		: (q.st == D_TW) ? chan_ok
		: (q.st != D_DMA);

	//////////////////////////////////////////////////////////////////////
	// cycle tracking and registered decode of the next state
	always_comb begin
		next_q = q;
		next_q.done = 1'b0;
		next_q.rdat = q.den ? bus.sd : own_io_rdata_i;
		if (busy_q & wr_q) begin
			next_q.wdat = bus.ad;
		end
		if (pce) begin
			unique case (q.st)
				D_IDLE: begin
					if (start_c) begin
						next_q.st = D_T2;
						next_q.kind = bus.proc_status;
						next_q.addr = {bus.proc_addr_hi, bus.ad};
						next_q.refresh = 1'b0;
					end else if (held_c) begin
						next_q.st = D_DMA;
						next_q.kind = sbr_pkg::PASSIVE;
						next_q.addr = dma_addr_i;
						next_q.refresh = dma_refresh_i;
						next_q.cnt = '0;
					end
				end
				D_T2: begin
					next_q.st = D_T3;
				end
				D_T3: begin
					next_q.st = (~io_q & chan_ok) ? D_T4 : D_TW;
				end
				D_TW: begin
					next_q.st = chan_ok ? D_T4 : D_TW;
				end
				D_T4: begin
					next_q.st = D_IDLE;
					next_q.kind = sbr_pkg::PASSIVE;
				end
				D_DMA: begin
					next_q.cnt = q.cnt + 1'b1;
					if (q.cnt == DMA_LAST) begin
						next_q.st = D_IDLE;
						next_q.refresh = 1'b0;
						next_q.done = 1'b1;
					end
				end
			endcase
		end
		// outputs follow the state being entered, so they come from flops
		n_busy = next_q.st inside {D_T2, D_T3, D_TW, D_T4};
		n_dma  = next_q.st == D_DMA;
		n_mem  = (next_q.kind == sbr_pkg::MEM_RD)
			| (next_q.kind == sbr_pkg::MEM_WR);
		n_io   = (next_q.kind == sbr_pkg::IO_RD)
			| (next_q.kind == sbr_pkg::IO_WR);
		// every dma transfer touches memory, refresh included
		next_q.crs = (n_busy & n_mem) | n_dma;
		next_q.b0 = next_q.crs & (next_q.refresh
			| (next_q.addr <= sbr_pkg::BANK0_LAST));
		next_q.b1 = next_q.crs & (next_q.refresh
			| ((next_q.addr >= sbr_pkg::BANK1_BASE)
			& (next_q.addr <= sbr_pkg::BANK1_LAST)));
		next_q.b2 = next_q.crs & next_q.refresh;
		next_q.ack0 = n_dma & next_q.refresh;
		next_q.rom_lo = n_busy & (next_q.kind == sbr_pkg::MEM_RD)
			& (next_q.addr >= sbr_pkg::ROM_LOW_BASE)
			& (next_q.addr <= sbr_pkg::ROM_LOW_LAST);
		next_q.rom_hi = n_busy & (next_q.kind == sbr_pkg::MEM_RD)
			& (next_q.addr >= sbr_pkg::ROM_HIGH_BASE);
		next_q.prn = n_busy & n_io
			& (next_q.addr[15:0] >= sbr_pkg::PRN_BASE)
			& (next_q.addr[15:0] <= sbr_pkg::PRN_LAST);
		next_q.dir = n_busy & ((next_q.kind == sbr_pkg::MEM_WR)
			| (next_q.kind == sbr_pkg::IO_WR));
		next_q.den = ~(n_busy & (next_q.kind == sbr_pkg::IO_RD)
			& (next_q.addr[15:0] <= sbr_pkg::OWN_IO_LAST));
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			q <= '0;
			q.st <= D_IDLE;
			q.kind <= sbr_pkg::PASSIVE;
			q.den <= sbr_pkg::BUF_EN_RST;
		end else begin
			q <= next_q;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// pins
	assign bus.system_address_out   = q.addr;
	assign bus.dev_ad_o             = q.rdat;
	assign bus.dev_ad_oe            = rd_q & (q.st inside {D_T3, D_TW, D_T4});
	assign bus.dev_sd_o             = q.wdat;
	assign bus.dev_sd_oe            = q.dir & (q.st inside {D_T3, D_TW, D_T4});
	assign bus.rom_low_read_enable  = q.rom_lo;
	assign bus.rom_high_read_enable = q.rom_hi;
	assign bus.common_row_strobe    = q.crs;
	assign bus.bank0_row_select     = q.b0;
	assign bus.bank1_row_select     = q.b1;
	assign bus.bank2_row_select     = q.b2;
	assign bus.buffer_direction     = q.dir;
	assign bus.buffer_drive_enable  = q.den;
	assign bus.printer_select       = q.prn;
	assign bus.bus_held_by_dma      = held_c;
	assign bus.channel0_acknowledge = q.ack0;
	assign dma_done_o               = q.done;
endmodule

// [sbr_pkg.sv]
// shared constants and types of the system bus ready and decode logic
package sbr_pkg;

	localparam int ADDR_W    = 20;
	localparam int DATA_W    = 8;
	localparam int HI_LSB    = 8;
	localparam int PCLK_DIV  = 3;
	localparam int TIMER_DIV = 4;
	localparam int DMA_LEN   = 4;
	localparam int DMA_CNT_W = 3;

	// processor cycle kind, as carried on the status lines
	typedef enum logic [2:0] {
		IO_RD   = 3'h1,
		IO_WR   = 3'h2,
		MEM_RD  = 3'h5,
		MEM_WR  = 3'h6,
		PASSIVE = 3'h7
	} sbr_kind_e;

	// memory decode windows
	localparam logic [19:0] ROM_LOW_BASE  = 20'hf0000;
	localparam logic [19:0] ROM_LOW_LAST  = 20'hf7fff;
	localparam logic [19:0] ROM_HIGH_BASE = 20'hf8000;
	localparam logic [19:0] BANK0_LAST    = 20'h3ffff;
	localparam logic [19:0] BANK1_BASE    = 20'h40000;
	localparam logic [19:0] BANK1_LAST    = 20'h7ffff;

	// i/o decode windows
	localparam logic [15:0] PRN_BASE      = 16'h0378;
	localparam logic [15:0] PRN_LAST      = 16'h037f;
	localparam logic [15:0] OWN_IO_LAST   = 16'h00ff;

	// values after reset
	localparam logic        BUF_EN_RST    = 1'b1;

endpackage

// [sbr_bus_if.sv]
// pins between the support chip and the processor with its bus devices
`timescale 1ns/1ps
interface sbr_bus_if;
	logic                 processor_clock_out;
	logic                 processor_clock_in;
	sbr_pkg::sbr_kind_e   proc_status;
	logic [19:8]          proc_addr_hi;
	logic [7:0]           host_ad_o;
	logic                 host_ad_oe;
	logic [7:0]           dev_ad_o;
	logic                 dev_ad_oe;
	logic [7:0]           ad;
	logic                 ready;
	logic                 bus_hold_lock;
	logic                 test_enable_in;
	logic                 channel_go_high;
	logic                 channel_wait_high;
	logic [19:0]          system_address_out;
	logic [7:0]           dev_sd_o;
	logic                 dev_sd_oe;
	logic [7:0]           host_sd_o;
	logic                 host_sd_oe;
	logic [7:0]           sd;
	logic                 rom_low_read_enable;
	logic                 rom_high_read_enable;
	logic                 common_row_strobe;
	logic                 bank0_row_select;
	logic                 bank1_row_select;
	logic                 bank2_row_select;
	logic                 buffer_direction;
	logic                 buffer_drive_enable;
	logic                 printer_select;
	logic                 bus_held_by_dma;
	logic                 channel0_acknowledge;

	// resolved levels of the two shared byte buses, low when undriven
	assign ad = host_ad_oe ? host_ad_o : (dev_ad_oe ? dev_ad_o : 8'h00);
	assign sd = dev_sd_oe ? dev_sd_o : (host_sd_oe ? host_sd_o : 8'h00);

	modport dev (
		output processor_clock_out, ready, dev_ad_o, dev_ad_oe,
		output system_address_out, dev_sd_o, dev_sd_oe,
		output rom_low_read_enable, rom_high_read_enable,
		output common_row_strobe, bank0_row_select, bank1_row_select,
		output bank2_row_select, buffer_direction, buffer_drive_enable,
		output printer_select, bus_held_by_dma, channel0_acknowledge,
		input  processor_clock_in, proc_status, proc_addr_hi, ad, sd,
		input  bus_hold_lock, test_enable_in, channel_go_high,
		input  channel_wait_high
	);

	modport host (
		output processor_clock_in, proc_status, proc_addr_hi,
		output host_ad_o, host_ad_oe, bus_hold_lock, test_enable_in,
		output channel_go_high, channel_wait_high, host_sd_o, host_sd_oe,
		input  processor_clock_out, ready, ad, sd, system_address_out,
		input  buffer_direction, buffer_drive_enable, bus_held_by_dma
	);
endinterface

// [sbr_div.sv]
// divider that turns an enable pulse train into a slower pulse train
`timescale 1ns/1ps
module sbr_div #(
	parameter int DIV = 3
) (
	input  wire logic clk_sys_i,
	input  wire logic rst_i,
	input  wire logic en_i,
	output logic      pulse_o
);
	localparam int CW = (DIV > 2) ? $clog2(DIV) : 1;
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          pulse;
	} sbr_div_s;

	sbr_div_s q;
	sbr_div_s next_q;

	// one output pulse for every DIV input pulses
	always_comb begin
		next_q = q;
		next_q.pulse = 1'b0;
		if (en_i) begin
			if (q.cnt == LAST) begin
				next_q.cnt = '0;
				next_q.pulse = 1'b1;
			end else begin
				next_q.cnt = q.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign pulse_o = q.pulse;
endmodule

// [sbr_host.sv]
// processor and bus device end: runs bus cycles and answers with data
`timescale 1ns/1ps
module sbr_host (
	input  wire logic                clk_sys_i,
	input  wire logic                rst_i,
	sbr_bus_if.host                  bus,
	input  wire logic                req_valid_i,
	input  wire sbr_pkg::sbr_kind_e  req_kind_i,
	input  wire logic [19:0]         req_addr_i,
	input  wire logic [7:0]          req_wdata_i,
	output logic                     req_ready_o,
	output logic                     rsp_valid_o,
	output logic [7:0]               rsp_rdata_o,
	input  wire logic                lock_i,
	input  wire logic                periph_extend_i,
	input  wire logic                video_extend_i,
	input  wire logic [7:0]          periph_rdata_i,
	output logic                     periph_wr_o,
	output logic [7:0]               periph_wdata_o
);
	typedef enum logic [5:0] {
		H_IDLE = 6'h01,
		H_T1   = 6'h02,
		H_T2   = 6'h04,
		H_T3   = 6'h08,
		H_TW   = 6'h10,
		H_T4   = 6'h20
	} sbr_hst_e;

	typedef struct packed {
		sbr_hst_e           st;
		sbr_pkg::sbr_kind_e kind;
		sbr_pkg::sbr_kind_e status;
		logic [19:0]        addr;
		logic [7:0]         wdat;
		logic [7:0]         rdat;
		logic [7:0]         ad_o;
		logic               ad_oe;
		logic               lock;
		logic [7:0]         sd_o;
		logic               rsp;
		logic               pwr;
		logic [7:0]         pwdat;
	} sbr_hst_s;

	sbr_hst_s q;
	sbr_hst_s next_q;
	logic     pce;
	logic     held;
	logic     wr_q;
	logic     in_data;

	assign pce     = bus.processor_clock_in;
	assign held    = bus.bus_held_by_dma;
	assign wr_q    = (q.kind == sbr_pkg::MEM_WR) | (q.kind == sbr_pkg::IO_WR);
	assign in_data = q.st inside {H_T2, H_T3, H_TW, H_T4};

	// no new cycle while dma owns the bus
	assign req_ready_o = (q.st == H_IDLE) & pce & ~held;

	//////////////////////////////////////////////////////////////////////
	// bus state sequence, one step per processor clock
	always_comb begin
		next_q = q;
		next_q.rsp = 1'b0;
		next_q.pwr = 1'b0;
		next_q.lock = lock_i;
		next_q.sd_o = periph_rdata_i;
		if (pce) begin
			unique case (q.st)
				H_IDLE: begin
					if (req_valid_i & ~held) begin
						next_q.st = H_T1;
						next_q.kind = req_kind_i;
						next_q.status = req_kind_i;
						next_q.addr = req_addr_i;
						next_q.wdat = req_wdata_i;
						next_q.ad_o = req_addr_i[7:0];
						next_q.ad_oe = 1'b1;
					end
				end
				H_T1: begin
					next_q.st = H_T2;
					next_q.ad_o = q.wdat;
					next_q.ad_oe = wr_q;
				end
				H_T2: begin
					next_q.st = H_T3;
					next_q.status = sbr_pkg::PASSIVE;
				end
				H_T3, H_TW: begin
					// waits are added for as long as ready stays low
					if (bus.ready) begin
						next_q.st = H_T4;
						next_q.rdat = bus.ad;
					end else begin
						next_q.st = H_TW;
					end
				end
				H_T4: begin
					next_q.st = H_IDLE;
					next_q.ad_oe = 1'b0;
					next_q.rsp = 1'b1;
					next_q.pwr = wr_q;
					next_q.pwdat = bus.sd;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			q <= '0;
			q.st <= H_IDLE;
			q.kind <= sbr_pkg::PASSIVE;
			q.status <= sbr_pkg::PASSIVE;
		end else begin
			q <= next_q;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// pins toward the support chip
	assign bus.processor_clock_in = bus.processor_clock_out;
	assign bus.proc_status        = q.status;
	assign bus.proc_addr_hi       = q.addr[19:8];
	assign bus.host_ad_o          = q.ad_o;
	assign bus.host_ad_oe         = q.ad_oe;
	assign bus.bus_hold_lock      = q.lock;
	assign bus.test_enable_in     = 1'b0;
	// ready lines idle in their ready state, flip only to stretch
	assign bus.channel_go_high    = ~periph_extend_i;
	assign bus.channel_wait_high  = video_extend_i;
	assign bus.host_sd_o          = q.sd_o;
	// devices drive data only inward and only while the buffer is on
	assign bus.host_sd_oe = in_data & ~wr_q & ~bus.buffer_direction
		& bus.buffer_drive_enable & ~held;

	assign rsp_valid_o    = q.rsp;
	assign rsp_rdata_o    = q.rdat;
	assign periph_wr_o    = q.pwr;
	assign periph_wdata_o = q.pwdat;
endmodule

// [sbr_checker.sv]
// assertions on the pins between the processor end and the support chip
`timescale 1ns/1ps
module sbr_checker (
	input wire logic        clk_sys_i,
	input wire logic        rst_i,
	input wire logic        processor_clock_out,
	input wire logic        ready,
	input wire logic        bus_hold_lock,
	input wire logic [19:0] system_address_out,
	input wire logic        rom_low_read_enable,
	input wire logic        rom_high_read_enable,
	input wire logic        common_row_strobe,
	input wire logic        bank0_row_select,
	input wire logic        bank1_row_select,
	input wire logic        bank2_row_select,
	input wire logic        buffer_drive_enable,
	input wire logic        printer_select,
	input wire logic        bus_held_by_dma,
	input wire logic        channel0_acknowledge
);
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);

	// dma only takes an unlocked bus, and the processor waits meanwhile
	a_dma_lock_free: assert property (
		$rose(bus_held_by_dma) |-> !bus_hold_lock)
		else $error("dma hold granted under lock");
	a_dma_ready_low: assert property (
		bus_held_by_dma && common_row_strobe |-> !ready)
		else $error("ready high during dma");

	// refresh opens every bank together with the common strobe
	a_refresh_all_banks: assert property (
		channel0_acknowledge |-> common_row_strobe && bank0_row_select &&
		bank1_row_select && bank2_row_select)
		else $error("refresh without all banks");

	// each select only inside its own window
	a_rom_low_window: assert property (
		rom_low_read_enable |->
		system_address_out inside {[20'hf0000:20'hf7fff]})
		else $error("low rom enable outside window");
	a_rom_high_window: assert property (
		rom_high_read_enable |-> system_address_out >= 20'hf8000)
		else $error("high rom enable outside window");
	a_bank_windows: assert property (
		!channel0_acknowledge |-> !bank2_row_select &&
		(!bank0_row_select || system_address_out <= 20'h3ffff) &&
		(!bank1_row_select || system_address_out[19:18] == 2'h1))
		else $error("bank select outside window");
	a_printer_window: assert property (
		printer_select |->
		system_address_out[15:0] inside {[16'h0378:16'h037f]})
		else $error("printer select outside window");
	a_own_port_read: assert property (
		!buffer_drive_enable && !bus_held_by_dma |->
		system_address_out[15:0] <= 16'h00ff)
		else $error("buffer disabled off own ports");

	// stall bound also covers the half-rate tick, so it is not exact at full rate
	a_clock_pulse_gap: assert property (
		processor_clock_out |=> !processor_clock_out [*2])
		else $error("processor clock pulses too close");
	a_clock_no_stall: assert property (
		!processor_clock_out [*6] |-> 1'b0)
		else $error("processor clock stalled");
endmodule

// [testbench.sv]
// bench joining both ends: decode, waits, dma, clocks and reset
`timescale 1ns/1ps
module testbench;
	typedef struct {
		sbr_pkg::sbr_kind_e kind;
		logic [19:0]        addr;
		logic [4:0]         sel;
	} sbr_row_s;

	// selects are {rom low, rom high, bank 0, bank 1, printer}
	sbr_row_s           rows [16] = '{
		'{sbr_pkg::MEM_RD, 20'hf0000, 5'h10}, '{sbr_pkg::MEM_RD, 20'hf7fff, 5'h10},
		'{sbr_pkg::MEM_RD, 20'hf8000, 5'h08}, '{sbr_pkg::MEM_RD, 20'hfffff, 5'h08},
		'{sbr_pkg::MEM_WR, 20'hf8000, 5'h00}, '{sbr_pkg::MEM_RD, 20'h00378, 5'h04},
		'{sbr_pkg::MEM_WR, 20'h3ffff, 5'h04}, '{sbr_pkg::MEM_RD, 20'h40000, 5'h02},
		'{sbr_pkg::MEM_WR, 20'h7ffff, 5'h02}, '{sbr_pkg::MEM_RD, 20'h80000, 5'h00},
		'{sbr_pkg::IO_RD, 20'h00378, 5'h01}, '{sbr_pkg::IO_WR, 20'h0037f, 5'h01},
		'{sbr_pkg::IO_RD, 20'h00377, 5'h00}, '{sbr_pkg::IO_WR, 20'h00380, 5'h00},
		'{sbr_pkg::IO_RD, 20'h000ff, 5'h00}, '{sbr_pkg::IO_RD, 20'h00100, 5'h00}};
	logic               clk_sys_i = 1'b0;
	logic               rst_i = 1'b1;
	logic               slow = 1'b0;
	logic               freq_tick_i = 1'b1;
	logic               req_valid_i = 1'b0;
	sbr_pkg::sbr_kind_e req_kind_i = sbr_pkg::IO_RD;
	logic [19:0]        req_addr_i = 20'h00000;
	logic [7:0]         req_wdata_i = 8'h00;
	logic               lock_i = 1'b0;
	logic               periph_extend_i = 1'b0;
	logic               video_extend_i = 1'b0;
	logic [7:0]         periph_rdata_i = 8'h00;
	logic               dma_req_i = 1'b0;
	logic               dma_refresh_i = 1'b0;
	logic [19:0]        dma_addr_i = 20'h00000;
	logic [7:0]         own_io_rdata_i = 8'h00;
	logic               req_ready_o;
	logic               rsp_valid_o;
	logic [7:0]         rsp_rdata_o;
	logic               periph_wr_o;
	logic [7:0]         periph_wdata_o;
	logic               timer_tick_o;
	logic               dma_done_o;
	logic [8:0]         seen;
	int                 lat;
	int                 num_errors = 0;
	int                 num_checks = 0;
	int                 cycles = 0;

	sbr_bus_if bus_if ();
	sbr_host sbr_host_i (.clk_sys_i, .rst_i, .bus(bus_if.host), .req_valid_i,
		.req_kind_i, .req_addr_i, .req_wdata_i, .req_ready_o, .rsp_valid_o,
		.rsp_rdata_o, .lock_i, .periph_extend_i, .video_extend_i,
		.periph_rdata_i, .periph_wr_o, .periph_wdata_o);
	sbr_dev sbr_dev_i (.clk_sys_i, .rst_i, .bus(bus_if.dev), .freq_tick_i,
		.dma_req_i, .dma_refresh_i, .dma_addr_i, .own_io_rdata_i,
		.timer_tick_o, .dma_done_o);
	sbr_checker sbr_checker_i (.clk_sys_i, .rst_i,
		.processor_clock_out(bus_if.processor_clock_out),
		.ready(bus_if.ready), .bus_hold_lock(bus_if.bus_hold_lock),
		.system_address_out(bus_if.system_address_out),
		.rom_low_read_enable(bus_if.rom_low_read_enable),
		.rom_high_read_enable(bus_if.rom_high_read_enable),
		.common_row_strobe(bus_if.common_row_strobe),
		.bank0_row_select(bus_if.bank0_row_select),
		.bank1_row_select(bus_if.bank1_row_select),
		.bank2_row_select(bus_if.bank2_row_select),
		.buffer_drive_enable(bus_if.buffer_drive_enable),
		.printer_select(bus_if.printer_select),
		.bus_held_by_dma(bus_if.bus_held_by_dma),
		.channel0_acknowledge(bus_if.channel0_acknowledge));

////////////////////////////////////////////////////////////////////////////////
	// clock, oscillator tick (half rate when slow) and hang guard
	initial forever #20 clk_sys_i = ~clk_sys_i;
	always @(negedge clk_sys_i) freq_tick_i <= slow ? ~freq_tick_i : 1'b1;
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			$display("unexpected at %0t: run too long", $time);
			end_of_test();
		end
	end

	task automatic check(input logic [19:0] got, exp, input string what);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: %s %h not %h", $time, what, got, exp);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// one processor transfer; ext bit 0 or 1 stretches through either channel
	task automatic xfer(input sbr_pkg::sbr_kind_e k, input logic [19:0] a,
		input logic [1:0] ext);
		int n;
		lat = 0;
		seen = 9'h000;
		req_valid_i = 1'b1;
		req_kind_i = k;
		req_addr_i = a;
		req_wdata_i = ~a[7:0];
		periph_rdata_i = a[7:0] ^ 8'h5a;
		own_io_rdata_i = a[7:0];
		{video_extend_i, periph_extend_i} = ext;
		for (n = 0; n < 20 && !req_ready_o; n++)
			@(negedge clk_sys_i);
		@(negedge clk_sys_i);
		req_valid_i = 1'b0;
		for (n = 1; n < 40 && lat == 0; n++) begin
			// released just after the edge that starts the first stretched wait
			if (n == (k inside {sbr_pkg::IO_RD, sbr_pkg::IO_WR} ? 13 : 10))
				{video_extend_i, periph_extend_i} = 2'h0;
			seen |= {bus_if.rom_low_read_enable, bus_if.rom_high_read_enable,
				bus_if.bank0_row_select, bus_if.bank1_row_select,
				bus_if.printer_select, bus_if.common_row_strobe,
				bus_if.buffer_direction, !bus_if.buffer_drive_enable, periph_wr_o};
			if (periph_wr_o)
				// cast keeps the inversion at byte width before widening
				check(periph_wdata_o, 8'(~a[7:0]), "write data");
			if (rsp_valid_o)
				lat = n;
			@(negedge clk_sys_i);
		end
	endtask

	// request dma and gather {banks 0-2, refresh, strobe, hold, done}
	task automatic dma(input logic refresh, input logic [19:0] a);
		int n;
		@(negedge clk_sys_i);
		seen = 9'h000;
		dma_req_i = 1'b1;
		dma_refresh_i = refresh;
		dma_addr_i = a;
		for (n = 0; n < 40 && !dma_done_o; n++) begin
			@(negedge clk_sys_i);
			seen |= {bus_if.bank0_row_select, bus_if.bank1_row_select,
				bus_if.bank2_row_select, bus_if.channel0_acknowledge,
				bus_if.common_row_strobe, bus_if.bus_held_by_dma, dma_done_o};
			if (n == 6)
				check(bus_if.system_address_out, a, "dma address");
		end
		dma_req_i = 1'b0;
	endtask

	// clocks between two pulses of the timer tick or the processor clock
	task automatic period(input logic tmr, output int p);
		int n;
		int s;
		s = -1;
		p = 0;
		for (n = 0; n < 80 && p == 0; n++) begin
			@(negedge clk_sys_i);
			if (tmr ? timer_tick_o : bus_if.processor_clock_out) begin
				if (s >= 0)
					p = n - s;
				s = n;
			end
		end
	endtask

////////////////////////////////////////////////////////////////////////////////
	// main sequence: decode table, then stretch, dma, clocks and reset
	initial begin
		sbr_row_s r;
		logic     w;
		logic     own;
		repeat (12) @(negedge clk_sys_i);
		rst_i = 1'b0;
		foreach (rows[i]) begin
			r = rows[i];
			w = r.kind inside {sbr_pkg::IO_WR, sbr_pkg::MEM_WR};
			own = r.kind == sbr_pkg::IO_RD && r.addr <= 20'h000ff;
			xfer(r.kind, r.addr, 2'h0);
			check(seen[8:4], r.sel, "selects");
			check(seen[3], !r.kind[2] ? 1'b0 : 1'b1, "row strobe");
			check(seen[2], w, "direction");
			check(seen[1], own, "buffer off");
			check(seen[0], w, "write pulse");
			check(20'(lat), r.kind[2] ? 20'h0d : 20'h10, "latency");
			if (!w)
				check(rsp_rdata_o, own ? r.addr[7:0] : r.addr[7:0] ^ 8'h5a, "read");
		end
		$display("decode rows done");
		xfer(sbr_pkg::MEM_RD, 20'h40010, 2'h1);
		check(20'(lat), 20'h10, "memory stretch");
		xfer(sbr_pkg::IO_WR, 20'h00379, 2'h2);
		check(20'(lat), 20'h13, "i/o stretch");
		$display("stretch done");
		lock_i = 1'b1;
		repeat (3) @(negedge clk_sys_i);
		dma_req_i = 1'b1;
		seen = 9'h000;
		repeat (30) begin
			@(negedge clk_sys_i);
			seen |= {bus_if.bus_held_by_dma, dma_done_o};
		end
		check(seen, 9'h000, "dma under lock");
		lock_i = 1'b0;
		dma(1'b0, 20'h45678);
		check(seen, 9'h027, "dma trace");
		dma(1'b1, 20'h00010);
		check(seen, 9'h07f, "refresh trace");
		$display("dma done");
		period(1'b0, lat);
		check(20'(lat), 20'h03, "processor clock");
		period(1'b1, lat);
		check(20'(lat), 20'h0c, "timer clock");
		slow = 1'b1;
		repeat (30) @(negedge clk_sys_i);
		period(1'b0, lat);
		check(20'(lat), 20'h06, "slow processor clock");
		period(1'b1, lat);
		check(20'(lat), 20'h18, "slow timer clock");
		slow = 1'b0;
		$display("clocks done");
		dma_req_i = 1'b1;
		dma_refresh_i = 1'b1;
		repeat (8) @(negedge clk_sys_i);
		rst_i = 1'b1;
		dma_req_i = 1'b0;
		repeat (4) @(negedge clk_sys_i);
		check({bus_if.ready, bus_if.buffer_drive_enable, bus_if.bus_held_by_dma,
			bus_if.common_row_strobe, bus_if.bank0_row_select,
			bus_if.channel0_acknowledge}, 20'h30, "reset state");
		check(bus_if.system_address_out, 20'h00000, "reset address");
		rst_i = 1'b0;
		xfer(sbr_pkg::MEM_RD, 20'hf8000, 2'h0);
		check(seen[8:4], 5'h08, "after reset");
		$display("reset done");
		end_of_test();
	end
endmodule
